/* phase_clock_pkg.sv */
// Constants shared by the four-phase clock generator and its divider
package phase_clock_pkg;

   // System clock
   localparam int unsigned CLK_SYS_HZ = 50_000_000;
   localparam int unsigned CLK_PERIOD_NS = 20;

   // Base oscillator rate, 10 MHz, one base period per phase
   localparam int unsigned BASE_OSC_HZ = 10_000_000;
   localparam int unsigned BASE_PERIOD_NS = 100;

   // Blanking after each base clock edge
   localparam int unsigned GUARD_NS = 10;

   // Whole processor cycle, four phases
   localparam int unsigned PHASE_CYCLE_NS = 400;
   localparam int unsigned PHASE_COUNT = 4;

   // Cycle counts derived from the times above
   localparam int unsigned BASE_CYCLES = CLK_SYS_HZ / BASE_OSC_HZ;
   localparam int unsigned GUARD_CYCLES_RAW = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GUARD_CYCLES = (GUARD_CYCLES_RAW < 1) ? 1 : GUARD_CYCLES_RAW;
   localparam int unsigned CYCLE_CLKS = PHASE_CYCLE_NS / CLK_PERIOD_NS;

   // Widths
   localparam int unsigned DIV_W = 3;
   localparam int unsigned GUARD_W = 2;
   localparam int unsigned STAGE_W = 2;

   // Values after reset, terminal counts and the guard load value
   localparam logic [STAGE_W-1:0] STAGE_RESET = 2'h3;
   localparam logic [STAGE_W-1:0] STAGE_LAST = 2'h3;
   localparam logic [PHASE_COUNT-1:0] PHASE_NONE = 4'h0;
   localparam logic [PHASE_COUNT-1:0] PHASE_ALL = 4'hf;
   localparam logic [GUARD_W-1:0] GUARD_LOAD = GUARD_W'(GUARD_CYCLES);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BASE_CYCLES - 1);

   // Gate state for maintenance control of the base clock
   typedef enum logic [1:0] {
      GATE_HALT,
      GATE_RUN,
      GATE_STEP
   } gate_state_t;

endpackage

/* base_tick_divider.sv */
// Divider that turns the system clock into the base oscillator enable
`timescale 1ns/1ns

module base_tick_divider
   import phase_clock_pkg::*;
#(
   parameter logic [DIV_W-1:0] LAST = DIV_LAST
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   output logic tick
);

   logic [DIV_W-1:0] count_q;
   logic [DIV_W-1:0] count_d;
   logic tick_q;
   logic tick_d;

   // Free-running count; the pulse marks the leading edge of each base period
   always_comb begin
      if (count_q == LAST) begin
         count_d = '0;
         tick_d = 1'b1;
      end else begin
         count_d = count_q + DIV_W'(1);
         tick_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
         tick_q <= 1'b0;
      end else begin
         count_q <= count_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule

/* four_phase_clock_generator.sv */
// Four-phase nonoverlapping clock generator with maintenance clock gating
`timescale 1ns/1ns

//
// Contract
// - Two-stage counter fed by the base clock, decoded to four phases.
// - Each phase is a positive pulse of about one base period.
// - Decoder outputs are blanked after each base clock edge, avoiding overlap.
// - A full four-phase sequence takes about four hundred nanoseconds.
// - Active-high and active-low logic copies carry the same phase timing.
// - One MOS phase set drives every chip of the processor chip set.
// - Base clock passes through maintenance gating before the counter.
module four_phase_clock_generator
   import phase_clock_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clock_run,
   input wire logic step_req,
   output logic [PHASE_COUNT-1:0] mos_phase_pulses,
   output logic [PHASE_COUNT-1:0] logic_phase_active_high,
   output logic [PHASE_COUNT-1:0] logic_phase_active_low,
   output logic cycle_start,
   output logic clock_running
);

   // Reset release synchroniser
   logic rst_meta_q;
   logic rst_sync_q;

   // Base oscillator enable
   logic base_osc_clock;

   // Maintenance gate
   gate_state_t gate_q;
   gate_state_t gate_d;
   logic gated_tick;

   // Step bookkeeping: marks that a step has left its starting state
   logic step_began_q;
   logic step_began_d;

   // Two-stage counter and blanking
   logic [STAGE_W-1:0] stage_q;
   logic [STAGE_W-1:0] stage_d;
   logic [GUARD_W-1:0] guard_q;
   logic [GUARD_W-1:0] guard_d;

   // Output registers
   logic [PHASE_COUNT-1:0] phase_q;
   logic [PHASE_COUNT-1:0] phase_d;
   logic [PHASE_COUNT-1:0] phase_n_q;
   logic [PHASE_COUNT-1:0] phase_n_d;
   logic cycle_start_q;
   logic cycle_start_d;
   logic running_q;
   logic running_d;

   // Reset asserts at once and releases two clocks later, so no flop leaves
   // reset on a metastable edge
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Stands in for the 10 MHz oscillator: one enable every base period.
   // It shares the synchronised reset, so its ticks start in step with
   // the gate and the counter.
   base_tick_divider #(
      .LAST(DIV_LAST)
   ) u_base_div (
      .clk_sys(clk_sys),
      .rst_n(rst_sync_q),
      .tick(base_osc_clock)
   );

   // Maintenance gate: run freely, halt, or deliver one full phase cycle.
   // Stopping only after the fourth phase keeps the chip set from seeing
   // a truncated processor cycle.
   always_comb begin
      gate_d = gate_q;
      unique case (gate_q)
         GATE_HALT: begin
            // Run wins over step when both are asked for
            if (clock_run) begin
               gate_d = GATE_RUN;
            end else if (step_req) begin
               gate_d = GATE_STEP;
            end
         end
         GATE_RUN: begin
            // Run ends only where a full cycle is done; that tick is swallowed
            if (!clock_run && base_osc_clock && stage_q == STAGE_LAST) begin
               gate_d = GATE_HALT;
            end
         end
         GATE_STEP: begin
            // The opening tick also leaves the last state, so wait for the flag
            if (clock_run) begin
               gate_d = GATE_RUN;
            end else if (base_osc_clock && stage_q == STAGE_LAST && step_began_q) begin
               gate_d = GATE_HALT;
            end
         end
         default: begin
            gate_d = GATE_HALT;
         end
      endcase
   end

   // Base clock reaches the counter only while the gate lets it through.
   // The tick that halts the gate is held back as well, so the fourth phase
   // stays up rather than a lone first phase starting behind the halt.
   assign gated_tick = base_osc_clock && (gate_q != GATE_HALT)
      && (gate_d != GATE_HALT);

   // Gate wakes halted; nothing reaches the counter until maintenance
   // logic asks for a run or a step
   always_ff @(posedge clk_sys or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         gate_q <= GATE_HALT;
      end else begin
         gate_q <= gate_d;
      end
   end

   // A step starts and ends with the counter in its last state; this flag
   // tells the closing tick from the opening one, so a step is never empty
   always_comb begin
      step_began_d = 1'b0;
      if (gate_q == GATE_STEP) begin
         step_began_d = step_began_q || base_osc_clock;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         step_began_q <= 1'b0;
      end else begin
         step_began_q <= step_began_d;
      end
   end

   // Two-stage counter advances once per gated base period; blanking is
   // reloaded on the same edge and counts down to zero
   always_comb begin
      stage_d = stage_q;
      guard_d = guard_q;
      if (gated_tick) begin
         stage_d = stage_q + STAGE_W'(1);
         guard_d = GUARD_LOAD;
      end else if (guard_q != '0) begin
         guard_d = guard_q - GUARD_W'(1);
      end
   end

   // Counter wakes in its last state so the first gated tick gives phase one
   always_ff @(posedge clk_sys or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         stage_q <= STAGE_RESET;
         guard_q <= '0;
      end else begin
         stage_q <= stage_d;
         guard_q <= guard_d;
      end
   end

   // Four-state decoder, blanked while the guard runs. With a stopped gate
   // the last phase simply holds, as a stopped clock would leave it.
   // Period is four base ticks, about 400 ns of the processor cycle.
   always_comb begin
      phase_d = PHASE_NONE;
      cycle_start_d = 1'b0;
      if (gated_tick) begin
         phase_d = PHASE_NONE;
      end else if (guard_q > GUARD_W'(1)) begin
         // Idle while the guard is one clock wide; kept for longer guards
         phase_d = PHASE_NONE;
      end else if (stage_q == STAGE_RESET && phase_q == PHASE_NONE
                   && guard_q == '0) begin
         phase_d = PHASE_NONE; // Nothing issued since reset
      end else begin
         phase_d = PHASE_NONE;
         phase_d[stage_q] = 1'b1;
         cycle_start_d = (guard_q == GUARD_W'(1)) && (stage_q == '0);
      end
      phase_n_d = ~phase_d;
      running_d = (gate_d != GATE_HALT);
   end

   // Every output comes from one of these flops; the MOS set and the
   // active-high copy share a register so their edges cannot skew
   always_ff @(posedge clk_sys or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         phase_q <= PHASE_NONE;
         phase_n_q <= PHASE_ALL;
         cycle_start_q <= 1'b0;
         running_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         phase_n_q <= phase_n_d;
         cycle_start_q <= cycle_start_d;
         running_q <= running_d;
      end
   end

   // One phase set fans out to all processor chips
   assign mos_phase_pulses = phase_q;
   assign logic_phase_active_high = phase_q;
   assign logic_phase_active_low = phase_n_q;

   // Status outputs let maintenance logic see each cycle start and where the gate stands
   assign cycle_start = cycle_start_q;
   assign clock_running = running_q;

endmodule

/* phase_properties.sv */
// Concurrent checks on the four-phase clock generator ports
`timescale 1ns/1ns
module phase_properties
   import phase_clock_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clock_run,
   input wire logic step_req,
   input wire logic [PHASE_COUNT-1:0] mos_phase_pulses,
   input wire logic [PHASE_COUNT-1:0] logic_phase_active_high,
   input wire logic [PHASE_COUNT-1:0] logic_phase_active_low,
   input wire logic cycle_start,
   input wire logic clock_running
);
   logic [PHASE_COUNT-1:0] ph;
   // Short alias keeps the properties readable
   assign ph = mos_phase_pulses;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Phase one stays four cycles, then one blank cycle
   sequence s_p1_pulse;
      ph[0] [*4] ##1 !ph[0];
   endsequence
   // Gate idle with no request pending
   sequence s_halted;
      !clock_running && !clock_run && !step_req;
   endsequence
   a_single_phase: assert property ($onehot0(ph))
      else $error("phases overlap");
   a_copies_match: assert property (logic_phase_active_high == ph
      && logic_phase_active_low == ~ph) else $error("phase copies differ");
   a_pulse_width: assert property ($rose(ph[0]) |-> s_p1_pulse)
      else $error("phase one width wrong");
   // After a blank cycle the next phase in turn follows
   a_phase_order: assert property ((ph == 4'h0 && $past(ph) != 4'h0)
      |=> ph == {$past(ph[2:0], 2), $past(ph[3], 2)}) else $error("phase order wrong");
   a_cycle_mark: assert property (cycle_start == $rose(ph[0]))
      else $error("cycle start misplaced");
   a_mid_span: assert property ($fell(ph[0]) |-> ##11 $rose(ph[3]))
      else $error("phase four late or early");
   a_start_latency: assert property (($rose(clock_run) && !clock_running)
      |-> ##[1:10] ph == 4'h1) else $error("run did not start phases");
   // Stopped gate must freeze the phases, held phase included
   a_halt_hold: assert property (s_halted [*3] |=> $stable(ph))
      else $error("phases moved while halted");
endmodule

bind four_phase_clock_generator phase_properties phase_properties_i (.clk_sys(clk_sys),
   .resetn(resetn), .clock_run(clock_run), .step_req(step_req),
   .mos_phase_pulses(mos_phase_pulses), .logic_phase_active_high(logic_phase_active_high),
   .logic_phase_active_low(logic_phase_active_low), .cycle_start(cycle_start),
   .clock_running(clock_running));

/* chip_set_model.sv */
// Model of the processor chip set running microcycles off the phases
`timescale 1ns/1ns
module chip_set_model
   import phase_clock_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [PHASE_COUNT-1:0] phases,
   output logic [15:0] microcycles
);
   logic p1_q;
   // A microcycle starts on phase one; a held phase must not count twice
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         microcycles <= 16'h0;
         p1_q <= 1'b0;
      end else begin
         p1_q <= phases[0];
         if (phases[0] && !p1_q)
            microcycles <= microcycles + 16'h1;
      end
   end
endmodule

/* tb.sv */
// Self-checking bench for the four-phase clock generator
`timescale 1ns/1ns
module tb;
   import phase_clock_pkg::*;
   logic clk_sys, resetn, clock_run, step_req, cycle_start, clock_running;
   logic [PHASE_COUNT-1:0] mos, act_h, act_l;
   logic [15:0] ucyc;
   int n_errors = 0;
   int tests_run = 0;
   four_phase_clock_generator four_phase_clock_generator_i (.clk_sys(clk_sys),
      .resetn(resetn), .clock_run(clock_run), .step_req(step_req),
      .mos_phase_pulses(mos), .logic_phase_active_high(act_h),
      .logic_phase_active_low(act_l), .cycle_start(cycle_start),
      .clock_running(clock_running));
   chip_set_model chip_set_model_i (.clk_sys(clk_sys), .resetn(resetn), .phases(mos),
      .microcycles(ucyc));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("Counts: %0d compares, %0d errors", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Walk n cycles from the first phase one cycle; hold keeps phase four once reached
   task automatic walk(input int n, input bit hold);
      logic [3:0] e;
      for (int i = 0; i < n; i++) begin
         e = (i % 5 == 4) ? 4'h0 : 4'h1 << ((i / 5) % 4);
         if (hold && i >= 15) e = 4'h8;
         check_val(mos, e);
         check_val({act_h, act_l}, {e, ~e});
         check_val(cycle_start, 16'(i % 20 == 0 && !(hold && i > 15)));
         @(negedge clk_sys);
      end
   endtask
   // Bounded wait for phase one after the gate opens
   task automatic wait_p1();
      int k = 0;
      while (mos !== 4'h1 && k < 12) begin
         @(negedge clk_sys);
         k++;
      end
      check_val(mos, 4'h1);
   endtask
   task automatic test_reset();
      @(negedge clk_sys);
      check_val({act_h, act_l, 3'h0, clock_running}, 16'h00f0);
      @(negedge clk_sys);
      resetn = 1'b1;
      repeat (3) @(negedge clk_sys);
      $display("reset test done");
   endtask
   task automatic test_run();
      clock_run = 1'b1;
      wait_p1();
      check_val(clock_running, 16'h1);
      walk(60, 1'b0);
      $display("run test done");
   endtask
   // Dropping run as phase one begins still completes the sequence, then freezes
   task automatic test_stop();
      clock_run = 1'b0;
      walk(30, 1'b1);
      check_val(clock_running, 16'h0);
      check_val(ucyc, 16'h4);
      $display("stop test done");
   endtask
   task automatic test_step();
      step_req = 1'b1;
      @(negedge clk_sys);
      step_req = 1'b0;
      wait_p1();
      walk(30, 1'b1);
      check_val(ucyc, 16'h5);
      check_val(clock_running, 16'h0);
      $display("step test done");
   endtask
   // Reset in mid-run must clear the outputs at once
   task automatic test_async_reset();
      clock_run = 1'b1;
      repeat (9) @(negedge clk_sys);
      resetn = 1'b0;
      #2;
      check_val({act_h, act_l, 3'h0, clock_running}, 16'h00f0);
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
      wait_p1();
      $display("async reset test done");
   endtask
   initial begin
      resetn = 1'b0;
      clock_run = 1'b0;
      step_req = 1'b0;
      test_reset();
      test_run();
      test_stop();
      test_step();
      test_async_reset();
      summarize();
   end
   // Tests need about 160 cycles; cut a hang well beyond that
   initial begin
      #40000;
      n_errors++;
      summarize();
   end
endmodule
